// *** src/acs_regs.vh ***
// control register layout, power modes, input types and timing constants
`ifndef ACS_REGS_VH
`define ACS_REGS_VH
`define ACS_CTRL_W        12
`define ACS_CTRL_RST      12'h000
`define ACS_PM_HI         11
`define ACS_PM_LO         10
`define ACS_CODING        9
`define ACS_REFSEL        8
`define ACS_ZERO          7
`define ACS_CH_HI         6
`define ACS_CH_LO         5
`define ACS_IT_HI         4
`define ACS_IT_LO         3
`define ACS_SEQ_HI        2
`define ACS_SEQ_LO        1
`define ACS_RANGE         0
`define ACS_PM_NORMAL     2'h0
`define ACS_PM_AUTOSHUT   2'h1
`define ACS_PM_AUTOSTBY   2'h2
`define ACS_PM_FULLSHUT   2'h3
`define ACS_IT_SINGLE     2'h0
`define ACS_IT_DIFF       2'h1
`define ACS_IT_PSEUDO     2'h2
`define ACS_IT_UNUSED     2'h3
`define ACS_SEQ_OFF       2'h0
`define ACS_SEQ_ON        2'h3
`define ACS_CONV_PERIODS  13
`define ACS_CLK_NS        10
`define ACS_WAKE_INT_NS   7000
`define ACS_WAKE_EXT_NS   600
`define ACS_CONVERSION_CLOCK_IN_TMO     64
`endif

// *** src/acs_ctrl_store.v ***
// control register store, loaded on chip select and write strobe
`timescale 1ns/10ps
module acs_ctrl_store
#(
  parameter W = 12
)
(
  input  wire         core_clk,   // system clock
  input  wire         rst,        // async reset, high
  input  wire         wr_en,      // one-cycle load strobe
  input  wire [W-1:0] wr_data,    // value to store
  output reg  [W-1:0] rd_data     // stored value
);
`include "acs_regs.vh"
  // holds the word; unaffected by power modes
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
      rd_data <= `ACS_CTRL_RST;                        // RQ14
    else if (wr_en)
      rd_data <= wr_data;                              // RQ4
  end
endmodule

// *** src/acs_seq_ctrl.v ***
// mode decode, channel sequencer and conversion control of a four-channel converter
// Operation
// [RQ1] pm 00: everything powered at all times
// [RQ2] pm 01: full shutdown after every conversion
// [RQ3] pm 10: reference on, buffer partial, rest off
// [RQ4] pm 11: all off, control word retained
// [RQ5] type 00: four single-ended inputs, minus grounded
// [RQ6] type 01: differential pairs 0+1-,1+0-,2+3-,3+2-
// [RQ7] type 10: pseudo differential, same pairs; 11 unused
// [RQ8] seq 00: convert channel from last write
// [RQ9] seq 11: step channel 0 to final, repeat
// [RQ10] differential sequencing skips inverse-polarity pairs
// [RQ11] conversion needs 13 conversion clock periods
// [RQ12] clock stops early: abort, no valid result
// [RQ13] host clears aborted state before reprogramming
// [RQ14] 12-bit write-only register, zero after reset
// [RQ15] fields at 11:10, 6:5, 4:3, 2:1
// [RQ16] start conversion on start input falling edge
// [RQ17] host avoids mixed sequencer settings 01, 10
// [RQ18] auto power-down modes wake before converting
`timescale 1ns/10ps
`include "acs_regs.vh"
module acs_seq_ctrl
#(
  parameter CTRL_W   = `ACS_CTRL_W,
  parameter CONV_N   = `ACS_CONV_PERIODS,
  parameter WAKE_INT = (`ACS_WAKE_INT_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS,
  parameter WAKE_EXT = (`ACS_WAKE_EXT_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS,
  parameter TMO      = `ACS_CONVERSION_CLOCK_IN_TMO
)
(
  input  wire              core_clk,            // system clock
  input  wire              rst,                 // async reset, high
  input  wire              cs_n,                // chip select, low
  input  wire              wr_n,                // write strobe, low
  input  wire [CTRL_W-1:0] db_in,               // parallel data bus
  input  wire              conversion_start_n,  // conversion start, falling edge
  input  wire              conversion_clock_in, // conversion clock, sampled
  output reg  [1:0]        pos_sel_reg,         // positive input index
  output reg  [2:0]        neg_sel_reg,         // negative input, 4 = analog_ground
  output reg               ref_pwr_reg,         // reference powered
  output reg  [1:0]        buf_pwr_reg,         // ref buffer: 0 off, 1 partial, 2 full
  output reg               core_pwr_reg,        // converter core powered
  output reg               busy_reg,            // conversion in progress
  output reg               done_reg,            // one-cycle valid result pulse
  output reg               abort_reg,           // one-cycle abort pulse
  output reg  [1:0]        conv_chan_reg,       // channel address of conversion
  output reg               coding_reg,          // output coding bit
  output reg               range_reg            // input range bit
);
  localparam ST_IDLE = 2'h0;
  localparam ST_WAKE = 2'h1;
  localparam ST_CONV = 2'h2;
  localparam ST_STOP = 2'h3;

  wire [CTRL_W-1:0] ctrl;
  reg               wr_d_reg;
  reg               cst_d_reg;
  reg               ck_d_reg;
  reg  [1:0]        state_reg;
  reg  [1:0]        state_next;
  reg  [1:0]        seq_ch_reg;
  reg  [1:0]        seq_ch_next;
  reg  [12:0]       cnt_reg;
  reg  [12:0]       cnt_next;
  reg  [4:0]        per_reg;
  reg  [4:0]        per_next;
  reg  [1:0]        cur_ch;
  reg               wr_evt;

  wire wr_act   = ~cs_n & ~wr_n;
  wire start_ev = cst_d_reg & ~conversion_start_n;   // RQ16
  wire ck_rise  = ~ck_d_reg & conversion_clock_in;
  wire [1:0] pm  = {ctrl[`ACS_PM_HI], ctrl[`ACS_PM_LO]};        // RQ15
  wire [1:0] it  = {ctrl[`ACS_IT_LO], ctrl[`ACS_IT_HI]};        // RQ15
  wire [1:0] sq  = {ctrl[`ACS_SEQ_HI], ctrl[`ACS_SEQ_LO]};      // RQ15
  wire [1:0] fin = {ctrl[`ACS_CH_HI], ctrl[`ACS_CH_LO]};        // RQ15
  wire seq_on    = (sq == `ACS_SEQ_ON);
  wire paired    = (it == `ACS_IT_DIFF) | (it == `ACS_IT_PSEUDO);
  wire auto_pd   = (pm == `ACS_PM_AUTOSHUT) | (pm == `ACS_PM_AUTOSTBY);
  wire [12:0] wake_len = ctrl[`ACS_REFSEL] ? WAKE_INT[12:0] : WAKE_EXT[12:0];

  ////////////////////////////////////////////////////////////////////////
  // write strobe edge loads the register, ignored while converting
  always @*
  begin
    wr_evt = wr_act & ~wr_d_reg & (state_reg == ST_IDLE);
  end

  acs_ctrl_store #(.W(CTRL_W)) u_store
  (
    .core_clk (core_clk),
    .rst      (rst),
    .wr_en    (wr_evt),
    .wr_data  (db_in),
    .rd_data  (ctrl)
  );

  ////////////////////////////////////////////////////////////////////////
  // edge detect registers
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      wr_d_reg  <= 1'b0;
      cst_d_reg <= 1'b1;
      ck_d_reg  <= 1'b0;
    end
    else
    begin
      wr_d_reg  <= wr_act;
      cst_d_reg <= conversion_start_n;
      ck_d_reg  <= conversion_clock_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // channel for the coming conversion
  always @*
  begin
    if (seq_on)
      cur_ch = seq_ch_reg;                             // RQ9
    else
      cur_ch = fin;                                    // RQ8
  end

  ////////////////////////////////////////////////////////////////////////
  // conversion state machine and sequencer step
  always @*
  begin
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    per_next    = per_reg;
    seq_ch_next = seq_ch_reg;
    if (wr_evt)
      seq_ch_next = 2'h0;                              // RQ9
    case (state_reg)
      ST_IDLE:
      begin
        if (start_ev && pm != `ACS_PM_FULLSHUT)
        begin
          per_next = 5'h00;
          cnt_next = 13'h0000;
          if (auto_pd)
            state_next = ST_WAKE;                      // RQ18
          else
            state_next = ST_CONV;
          if (seq_on)
          begin
            if (seq_ch_reg >= fin || (paired && ({1'b0, seq_ch_reg} + 3'h2) > {1'b0, fin}))
              seq_ch_next = 2'h0;                      // RQ9
            else if (paired)
              seq_ch_next = seq_ch_reg + 2'h2;         // RQ10
            else
              seq_ch_next = seq_ch_reg + 2'h1;
          end
        end
      end
      ST_WAKE:
      begin
        cnt_next = cnt_reg + 13'h0001;
        if (cnt_reg + 13'h0001 >= wake_len)            // RQ18
        begin
          cnt_next   = 13'h0000;
          state_next = ST_CONV;
        end
      end
      ST_CONV:
      begin
        if (ck_rise)
        begin
          cnt_next = 13'h0000;
          per_next = per_reg + 5'h01;
          if (per_reg + 5'h01 >= CONV_N[4:0])          // RQ11
            state_next = ST_STOP;
        end
        else
        begin
          cnt_next = cnt_reg + 13'h0001;
          if (cnt_reg >= TMO[12:0])                    // RQ12
            state_next = ST_STOP;
        end
      end
      ST_STOP:
        state_next = ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // state, sequencer and result flags
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg     <= ST_IDLE;
      cnt_reg       <= 13'h0000;
      per_reg       <= 5'h00;
      seq_ch_reg    <= 2'h0;
      busy_reg      <= 1'b0;
      done_reg      <= 1'b0;
      abort_reg     <= 1'b0;
      conv_chan_reg <= 2'h0;
    end
    else
    begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      per_reg    <= per_next;
      seq_ch_reg <= seq_ch_next;
      busy_reg   <= (state_next != ST_IDLE) & (state_next != ST_STOP);
      done_reg   <= (state_reg == ST_CONV) & (state_next == ST_STOP) & ck_rise;   // RQ11
      abort_reg  <= (state_reg == ST_CONV) & (state_next == ST_STOP) & ~ck_rise;  // RQ12
      if (state_reg == ST_IDLE && state_next != ST_IDLE)
        conv_chan_reg <= cur_ch;                       // RQ16
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // input mux select and power control
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pos_sel_reg  <= 2'h0;
      neg_sel_reg  <= 3'h4;
      ref_pwr_reg  <= 1'b1;
      buf_pwr_reg  <= 2'h2;
      core_pwr_reg <= 1'b1;
      coding_reg   <= 1'b0;
      range_reg    <= 1'b0;
    end
    else
    begin
      coding_reg  <= ctrl[`ACS_CODING];
      range_reg   <= ctrl[`ACS_RANGE];
      pos_sel_reg <= cur_ch;                           // RQ5
      if (it == `ACS_IT_SINGLE || it == `ACS_IT_UNUSED)
        neg_sel_reg <= 3'h4;                           // RQ5
      else
        neg_sel_reg <= {1'b0, cur_ch[1], ~cur_ch[0]};  // RQ6 RQ7
      case (pm)
        `ACS_PM_NORMAL:
        begin
          ref_pwr_reg  <= 1'b1;                        // RQ1
          buf_pwr_reg  <= 2'h2;
          core_pwr_reg <= 1'b1;
        end
        `ACS_PM_AUTOSHUT:
        begin
          ref_pwr_reg  <= state_next != ST_IDLE;       // RQ2
          buf_pwr_reg  <= (state_next != ST_IDLE) ? 2'h2 : 2'h0;
          core_pwr_reg <= state_next != ST_IDLE;
        end
        `ACS_PM_AUTOSTBY:
        begin
          ref_pwr_reg  <= 1'b1;                        // RQ3
          buf_pwr_reg  <= (state_next != ST_IDLE) ? 2'h2 : 2'h1;
          core_pwr_reg <= state_next != ST_IDLE;
        end
        default:
        begin
          ref_pwr_reg  <= 1'b0;                        // RQ4
          buf_pwr_reg  <= 2'h0;
          core_pwr_reg <= 1'b0;
        end
      endcase
    end
  end
endmodule

// *** bench/acs_chk_asserts.sv ***
// port checks of the converter control block
`timescale 1ns/10ps
module acs_chk
(
  input wire       core_clk,           // clock
  input wire       rst,                // reset
  input wire       conversion_start_n, // start
  input wire [1:0] pos_sel_reg,        // plus side
  input wire [2:0] neg_sel_reg,        // minus side
  input wire       core_pwr_reg,       // core power
  input wire       busy_reg,           // busy
  input wire       done_reg,           // result
  input wire       abort_reg,          // abort
  input wire [1:0] conv_chan_reg       // channel
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // flags, conversion length, mux pairing
  a_done_pulse: assert property (done_reg |=> !done_reg)
    else $error("done held too long");
  a_abort_pulse: assert property (abort_reg |=> !abort_reg)
    else $error("abort held too long");
  a_flag_excl: assert property (!(done_reg && abort_reg))
    else $error("done with abort");
  a_done_ends: assert property (done_reg |-> !busy_reg && $past(busy_reg))
    else $error("done without conversion");
  a_min_length: assert property ($rose(busy_reg) |-> busy_reg[*6])
    else $error("conversion too short");
  a_chan_hold: assert property (busy_reg && $past(busy_reg) |-> $stable(conv_chan_reg))
    else $error("channel moved in conversion");
  a_pair_map: assert property (neg_sel_reg != 3'h4 |-> neg_sel_reg == {1'b0, pos_sel_reg[1], ~pos_sel_reg[0]})
    else $error("bad pair");
  a_core_on: assert property (busy_reg |-> core_pwr_reg)
    else $error("converting unpowered");
  a_start_taken: assert property ($fell(conversion_start_n) && core_pwr_reg && !busy_reg && !done_reg
    && !abort_reg |=> busy_reg)
    else $error("start missed");
  c_done: cover property (done_reg);
  c_abort: cover property (abort_reg);
  c_pair: cover property (busy_reg && neg_sel_reg != 3'h4);
endmodule
bind acs_seq_ctrl acs_chk u_chk
(
  .core_clk(core_clk),
  .rst(rst),
  .conversion_start_n(conversion_start_n),
  .pos_sel_reg(pos_sel_reg),
  .neg_sel_reg(neg_sel_reg),
  .core_pwr_reg(core_pwr_reg),
  .busy_reg(busy_reg),
  .done_reg(done_reg),
  .abort_reg(abort_reg),
  .conv_chan_reg(conv_chan_reg)
);

// *** bench/acs_host.sv ***
// host model: register writes, conversion start and clock
`timescale 1ns/10ps
module acs_host
(
  input  wire        core_clk,  // clock
  input  wire        busy_reg,  // busy
  input  wire        done_reg,  // result
  input  wire        abort_reg, // abort
  output reg         cs_n,      // select
  output reg         wr_n,      // strobe
  output reg  [11:0] db_in,     // bus
  output reg         start_n,   // start
  output reg         cclk       // conv clock
);
  integer i;
  // idle levels, conversion clock still
  initial
  begin
    cs_n = 1'b1;
    wr_n = 1'b1;
    db_in = 12'h000;
    start_n = 1'b1;
    cclk = 1'b0;
  end
  ////////////////////////////////////////
  // one strobed write, released bus inverted
  task wr(input [11:0] w);
  begin
    @(negedge core_clk);
    cs_n = 1'b0;
    wr_n = 1'b0;
    db_in = w & 12'hF7F;
    @(negedge core_clk);
    cs_n = 1'b1;
    wr_n = 1'b1;
    db_in = ~db_in;
    repeat (3) @(negedge core_clk);
  end
  endtask
  // start, optional wake wait, n clock periods
  task cv(input integer n, input integer wk, output reg d, output reg a);
  begin
    d = 1'b0;
    a = 1'b0;
    @(negedge core_clk);
    start_n = 1'b0;
    for (i = 0; i < 4 && !busy_reg; i = i + 1)
      @(negedge core_clk);
    repeat (wk) @(negedge core_clk);
    for (i = 0; i < 4 * n + 20; i = i + 1)
    begin
      cclk = (i < 4 * n) && (i % 4 < 2);
      @(negedge core_clk);
      d = d | done_reg;
      a = a | abort_reg;
    end
    start_n = 1'b1;
  end
  endtask
endmodule

// *** bench/test_adc_mode_and_sequencer_control.sv ***
// self-checking bench of the converter mode and sequencer control
`timescale 1ns/10ps
module test_adc_mode_and_sequencer_control;
  reg         core_clk;
  reg         rst;
  reg         d;
  reg         a;
  wire        cs_n, wr_n, start_n, cclk, refp, corep, busy, done, abort, coding, range;
  wire [11:0] db_in;
  wire [1:0]  pos, bufp, chan;
  wire [2:0]  neg;
  integer     fails = 0;
  integer     checks_done = 0;
  integer     t, c, k;
  acs_seq_ctrl #(.WAKE_INT(5), .WAKE_EXT(3), .TMO(8)) dut (.core_clk(core_clk), .rst(rst), .cs_n(cs_n),
    .wr_n(wr_n), .db_in(db_in), .conversion_start_n(start_n), .conversion_clock_in(cclk), .pos_sel_reg(pos),
    .neg_sel_reg(neg), .ref_pwr_reg(refp), .buf_pwr_reg(bufp), .core_pwr_reg(corep), .busy_reg(busy),
    .done_reg(done), .abort_reg(abort), .conv_chan_reg(chan), .coding_reg(coding), .range_reg(range));
  acs_host h (.core_clk(core_clk), .busy_reg(busy), .done_reg(done), .abort_reg(abort), .cs_n(cs_n),
    .wr_n(wr_n), .db_in(db_in), .start_n(start_n), .cclk(cclk));
  ////////////////////////////////////////
  // clock, compare and verdict
  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;
  task chk(input [11:0] got, input [11:0] exp);
  begin
    checks_done = checks_done + 1;
    if (got !== exp)
    begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      fails = fails + 1;
    end
  end
  endtask
  task close_out;
  begin
    if (fails == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask
  // word: power, channel, type {bit4,bit3}, sequencer 00 or 11 only
  function [11:0] wd(input [1:0] pm, input [1:0] ch, input [1:0] it, input [1:0] sq);
    wd = {pm, 3'h0, ch, it, sq, 1'b0};
  endfunction
  ////////////////////////////////////////
  // every type (single, diff, pseudo, unused) and address, one conversion each
  task t_types;
  begin
    chk({pos, neg, refp, bufp, corep}, 12'h04D);
    for (t = 0; t < 4; t = t + 1)
      for (c = 0; c < 4; c = c + 1)
      begin
        h.wr(wd(2'h0, c[1:0], (t == 1) ? 2'h2 : (t == 2) ? 2'h1 : t[1:0], 2'h0));
        chk(pos, c);
        chk(neg, (t == 0 || t == 3) ? 4 : {c[1], ~c[0]});
        h.cv(13, 0, d, a);
        chk({d, a, chan}, {2'h2, c[1:0]});
      end
    chk({refp, bufp, corep}, 12'hD);
  end
  endtask
  // sequencer single to channel 2, then differential to 3
  task t_seq;
  begin
    h.wr(wd(2'h0, 2'h2, 2'h0, 2'h3));
    for (k = 0; k < 4; k = k + 1)
    begin
      h.cv(13, 0, d, a);
      chk(chan, k % 3);
    end
    h.wr(wd(2'h0, 2'h3, 2'h2, 2'h3));
    for (k = 0; k < 3; k = k + 1)
    begin
      h.cv(13, 0, d, a);
      chk(chan, (k % 2) * 2);
    end
  end
  endtask
  // clock stopped after 12 periods, then recovery
  task t_abort;
  begin
    h.wr(wd(2'h0, 2'h1, 2'h0, 2'h0));
    h.cv(12, 0, d, a);
    chk({d, a}, 2'h1);
    h.cv(13, 0, d, a);
    chk({d, a}, 2'h2);
  end
  endtask
  // standby, autoshutdown, full shutdown with retention
  task t_power;
  begin
    h.wr(wd(2'h2, 2'h0, 2'h0, 2'h0));
    chk({refp, bufp, corep}, 12'hA);
    h.cv(13, 4, d, a);
    chk(d, 1);
    // internal reference: longer wake swallows an early first clock rise
    h.wr(wd(2'h2, 2'h0, 2'h0, 2'h0) | 12'h100);
    h.cv(13, 4, d, a);
    chk({d, a}, 2'h1);
    h.cv(13, 6, d, a);
    chk({d, a}, 2'h2);
    h.wr(wd(2'h1, 2'h0, 2'h0, 2'h0));
    chk({refp, bufp, corep}, 0);
    h.cv(13, 4, d, a);
    chk(d, 1);
    chk({refp, bufp, corep}, 0);
    h.wr(wd(2'h3, 2'h2, 2'h0, 2'h0) | 12'h201);
    h.cv(13, 0, d, a);
    chk({d, busy, refp, bufp, corep}, 0);
    chk({coding, range, pos}, 12'hE);
  end
  endtask
  ////////////////////////////////////////
  // reset, scenarios, watchdog
  initial
  begin
    rst = 1'b1;
    repeat (12) @(negedge core_clk);
    rst = 1'b0;
    t_types;
    t_seq;
    t_abort;
    t_power;
    close_out;
  end
  initial
  begin
    #200000;
    fails = fails + 1;
    close_out;
  end
endmodule
